// file: hw/edge_trigger.v
// synchronised edge detector with a two-bit edge selection
`timescale 1ns/1ps
`include "irq_defines.vh"

module edge_trigger (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // source and selection
  input wire sig_in,
  input wire [1:0] edge_sel,
  // one-cycle event
  output reg hit_r
);

  reg sync1_r;
  reg sync2_r;
  reg prev_r;
  wire rise;
  wire fall;
  reg hit_nxt;

  // edges only look at the second stage, never the first
  assign rise = sync2_r & ~prev_r;
  assign fall = ~sync2_r & prev_r;

  // selection decode, off gives no event at all
  always @* begin
    case (edge_sel)
      `EDGE_RISE: hit_nxt = rise;
      `EDGE_FALL: hit_nxt = fall;
      `EDGE_BOTH: hit_nxt = rise | fall;
      default: hit_nxt = 1'b0;
    endcase
  end

  // two-stage synchroniser, history and registered event
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r <= 1'b0;
      hit_r <= 1'b0;
    end else begin
      sync1_r <= sig_in;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
      hit_r <= hit_nxt;
    end
  end

endmodule // edge_trigger

// file: hw/irq_defines.vh
// register map, field positions and codes of the interrupt vectoring block
`ifndef IRQ_DEFINES_VH
`define IRQ_DEFINES_VH

// byte offsets on the register bus
`define REG_CTRL 5'h00
`define REG_FLAGS 5'h04
`define REG_EDGE 5'h08
`define REG_POWER 5'h0c
`define REG_STATUS 5'h10

// control register fields
`define CTRL_GIE 0
`define CTRL_GROUP0_ENABLE 1
`define CTRL_EXTE 2
`define CTRL_C0E 3
`define CTRL_NFE 4
`define CTRL_HALE 5
`define CTRL_RST 8'h00

// flag register fields
`define FLG_MF0 0
`define FLG_EXT 1
`define FLG_C0 2
`define FLG_NF 3
`define FLG_HAL 4
`define FLG_RST 7'h00

// edge register fields
`define EDG_HALL 0
`define EDG_EXT 2
`define EDG_C0 4
`define EDG_NF_LO 6
`define EDG_NF_HI 7
`define EDG_EXT_PU 8
`define EDG_NF_PU 9
`define EDG_RST 10'h000

// power register fields
`define PWR_SLEEP 0
`define PWR_IDLE 1

// status register fields
`define STS_SERVICE 13

// edge selection codes
`define EDGE_OFF 2'b00
`define EDGE_RISE 2'b01
`define EDGE_FALL 2'b10
`define EDGE_BOTH 2'b11

// program counter width and vector addresses, lowest served first
`define PC_W 13
`define VEC_EXT 13'h0004
`define VEC_C0 13'h0008
`define VEC_NF 13'h000c
`define VEC_MF0 13'h0010

`endif

// file: hw/irq_vectoring.v
// interrupt flags, enables and vectoring toward the core pc and stack
`timescale 1ns/1ps
`include "irq_defines.vh"

module irq_vectoring (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // avalon-mm slave
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // event sources, asynchronous
  input wire filtered_hall_a,
  input wire filtered_hall_b,
  input wire filtered_hall_c,
  input wire ext_irq_pin,
  input wire comparator_zero_out,
  input wire noise_filtered_input_pin,
  // core side, same clock
  input wire insn_boundary,
  input wire [`PC_W-1:0] next_pc,
  input wire stack_full,
  input wire return_from_interrupt,
  input wire [`PC_W-1:0] stack_top,
  output reg stack_push_r,
  output reg [`PC_W-1:0] stack_push_data_r,
  output reg stack_pop_r,
  output reg pc_load_r,
  output reg [`PC_W-1:0] pc_load_value_r,
  // power and pin control
  output wire low_power_sleep,
  output wire low_power_idle,
  output wire ext_pull_up_en,
  output wire noise_filtered_input_pin_pull_up_en
);

  localparam ST_RUN = 1'b0;
  localparam ST_POP = 1'b1;

  // software state
  reg [7:0] ctrl_r;
  reg [7:0] ctrl_nxt;
  reg [6:0] flags_r;
  reg [6:0] flags_nxt;
  reg [9:0] edge_r;
  reg [1:0] power_r;
  reg [1:0] power_nxt;
  reg state_r;
  reg service_r;
  reg [`PC_W-1:0] last_vec_r;

  // bus handshake
  reg ack_r;
  wire bus_req;
  wire wr_take;
  wire rd_first;

  // source events
  wire [2:0] hall_hit;
  wire ext_hit;
  wire c0_hit;
  wire nf_hit;
  wire [1:0] nf_sel;

  // request and arbitration
  wire gie;
  wire [2:0] hall_en;
  wire [2:0] hall_flag;
  wire req_ext;
  wire req_c0;
  wire req_nf;
  wire req_mf0;
  wire any_req;
  wire take;
  reg [`PC_W-1:0] vec_sel;
  reg [6:0] svc_clr;

  // flag update terms
  reg [6:0] hw_set;
  reg [6:0] clr_v;
  wire [6:0] sw_set;
  wire flags_wr;
  wire wake;

  // one wait cycle per access so read data can come from a flop
  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_r;
  assign wr_take = avs_write & ack_r;
  assign rd_first = avs_read & ~ack_r;

  // enable and flag views
  assign gie = ctrl_r[`CTRL_GIE];
  assign hall_en = ctrl_r[`CTRL_HALE+2:`CTRL_HALE];
  assign hall_flag = flags_r[`FLG_HAL+2:`FLG_HAL];
  assign nf_sel = {edge_r[`EDG_NF_HI], edge_r[`EDG_NF_LO]};

  // pull-high choice reaches the pin whatever the edge setting
  assign ext_pull_up_en = edge_r[`EDG_EXT_PU];
  assign noise_filtered_input_pin_pull_up_en = edge_r[`EDG_NF_PU];

  // power mode outputs
  assign low_power_sleep = power_r[`PWR_SLEEP];
  assign low_power_idle = power_r[`PWR_IDLE];

  // one detector per hall phase
  edge_trigger u_hall_a (
    .clk(clk),
    .rst_n(rst_n),
    .sig_in(filtered_hall_a),
    .edge_sel(edge_r[`EDG_HALL+1:`EDG_HALL]),
    .hit_r(hall_hit[0])
  );

  edge_trigger u_hall_b (
    .clk(clk),
    .rst_n(rst_n),
    .sig_in(filtered_hall_b),
    .edge_sel(edge_r[`EDG_HALL+1:`EDG_HALL]),
    .hit_r(hall_hit[1])
  );

  edge_trigger u_hall_c (
    .clk(clk),
    .rst_n(rst_n),
    .sig_in(filtered_hall_c),
    .edge_sel(edge_r[`EDG_HALL+1:`EDG_HALL]),
    .hit_r(hall_hit[2])
  );

  // external pin detector
  edge_trigger u_ext (
    .clk(clk),
    .rst_n(rst_n),
    .sig_in(ext_irq_pin),
    .edge_sel(edge_r[`EDG_EXT+1:`EDG_EXT]),
    .hit_r(ext_hit)
  );

  // comparator output is analog-side, so it is synchronised too
  edge_trigger u_c0 (
    .clk(clk),
    .rst_n(rst_n),
    .sig_in(comparator_zero_out),
    .edge_sel(edge_r[`EDG_C0+1:`EDG_C0]),
    .hit_r(c0_hit)
  );

  // filtered input pin detector
  edge_trigger u_nf (
    .clk(clk),
    .rst_n(rst_n),
    .sig_in(noise_filtered_input_pin),
    .edge_sel(nf_sel),
    .hit_r(nf_hit)
  );

  // a flag alone never vectors, its enable must be set too
  assign req_ext = flags_r[`FLG_EXT] & ctrl_r[`CTRL_EXTE];
  assign req_c0 = flags_r[`FLG_C0] & ctrl_r[`CTRL_C0E];
  assign req_nf = flags_r[`FLG_NF] & ctrl_r[`CTRL_NFE];
  // group request needs its own flag, group enable and one phase whose flag and enable are both set
  assign req_mf0 = flags_r[`FLG_MF0] & ctrl_r[`CTRL_GROUP0_ENABLE]
                   & (|(hall_flag & hall_en));

  // global gate in front of every source
  assign any_req = gie & (req_ext | req_c0 | req_nf | req_mf0);

  // a full stack holds the request off; a pending return goes first
  assign take = any_req & ~stack_full & insn_boundary
                & (state_r == ST_RUN) & ~return_from_interrupt;

  // fixed order, lowest vector address first
  always @* begin
    vec_sel = `VEC_MF0;
    svc_clr = 7'h00;
    if (req_ext) begin
      vec_sel = `VEC_EXT;
      svc_clr[`FLG_EXT] = 1'b1;
    end else if (req_c0) begin
      vec_sel = `VEC_C0;
      svc_clr[`FLG_C0] = 1'b1;
    end else if (req_nf) begin
      vec_sel = `VEC_NF;
      svc_clr[`FLG_NF] = 1'b1;
    end else begin
      vec_sel = `VEC_MF0;
      // phase flags are left for software to clear
      svc_clr[`FLG_MF0] = 1'b1;
    end
  end

  // hardware set terms, independent of any enable
  always @* begin
    hw_set = 7'h00;
    hw_set[`FLG_HAL+2:`FLG_HAL] = hall_hit;
    hw_set[`FLG_MF0] = |hall_hit;
    hw_set[`FLG_EXT] = ext_hit;
    hw_set[`FLG_C0] = c0_hit;
    hw_set[`FLG_NF] = nf_hit;
  end

  // software writes a whole flag word: ones set, zeros clear
  assign flags_wr = wr_take & (avs_address == `REG_FLAGS);
  assign sw_set = flags_wr ? avs_writedata[6:0] : 7'h00;

  // clears from software and from service
  always @* begin
    clr_v = take ? svc_clr : 7'h00;
    if (flags_wr) begin
      clr_v = clr_v | ~avs_writedata[6:0];
    end
  end

  // set beats clear, so a blocked or racing event is never lost
  always @* begin
    flags_nxt = (flags_r & ~clr_v) | hw_set | sw_set;
  end

  // only a flag going from clear to set wakes; one already set does not
  assign wake = |((hw_set | sw_set) & ~flags_r);

  // control register: software write, then service clears global enable
  always @* begin
    ctrl_nxt = ctrl_r;
    if (wr_take && (avs_address == `REG_CTRL)) begin
      ctrl_nxt = avs_writedata[7:0];
    end
    if (take) begin
      // no nesting unless the handler sets it again itself
      ctrl_nxt[`CTRL_GIE] = 1'b0;
    end
  end

  // power mode: entered by software, left on wake
  always @* begin
    power_nxt = power_r;
    if (wr_take && (avs_address == `REG_POWER)) begin
      power_nxt = avs_writedata[1:0];
    end
    if (wake) begin
      // a wake racing the entry write wins, so no event is slept through
      power_nxt = 2'b00;
    end
  end

  // register state
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= `CTRL_RST;
      flags_r <= `FLG_RST;
      edge_r <= `EDG_RST;
      power_r <= 2'b00;
    end else begin
      ctrl_r <= ctrl_nxt;
      flags_r <= flags_nxt;
      power_r <= power_nxt;
      if (wr_take && (avs_address == `REG_EDGE)) begin
        edge_r <= avs_writedata[9:0];
      end
    end
  end

  // bus acknowledge and registered read data
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack_r <= bus_req & ~ack_r;
      if (rd_first) begin
        if (avs_address == `REG_CTRL) begin
          avs_readdata <= {24'h00_0000, ctrl_r};
        end else if (avs_address == `REG_FLAGS) begin
          avs_readdata <= {25'h000_0000, flags_r};
        end else if (avs_address == `REG_EDGE) begin
          avs_readdata <= {22'h00_0000, edge_r};
        end else if (avs_address == `REG_POWER) begin
          avs_readdata <= {30'h0000_0000, power_r};
        end else if (avs_address == `REG_STATUS) begin
          avs_readdata <= {18'h0_0000, service_r, last_vec_r};
        end else begin
          // unmapped reads answer zero
          avs_readdata <= 32'h0000_0000;
        end
      end
    end
  end

  // entry and return sequencing toward the core
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_RUN;
      stack_push_r <= 1'b0;
      stack_push_data_r <= {`PC_W{1'b0}};
      stack_pop_r <= 1'b0;
      pc_load_r <= 1'b0;
      pc_load_value_r <= {`PC_W{1'b0}};
      service_r <= 1'b0;
      last_vec_r <= {`PC_W{1'b0}};
    end else begin
      stack_push_r <= 1'b0;
      stack_pop_r <= 1'b0;
      pc_load_r <= 1'b0;
      case (state_r)
        ST_RUN: begin
          if (return_from_interrupt) begin
            // pop now, the top is loaded next cycle
            stack_pop_r <= 1'b1;
            state_r <= ST_POP;
          end else if (take) begin
            stack_push_r <= 1'b1;
            stack_push_data_r <= next_pc;
            pc_load_r <= 1'b1;
            pc_load_value_r <= vec_sel;
            last_vec_r <= vec_sel;
            service_r <= 1'b1;
          end
        end
        ST_POP: begin
          pc_load_r <= 1'b1;
          pc_load_value_r <= stack_top;
          service_r <= 1'b0;
          state_r <= ST_RUN;
        end
        default: begin
          state_r <= ST_RUN;
        end
      endcase
    end
  end

endmodule // irq_vectoring

// file: tb/core_model.sv
// behavioural core: pc source and a small hardware stack
`timescale 1ns/1ps

module core_model #(parameter DEPTH = 2) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // bench control
  input wire ret_req,
  input wire [12:0] pc_in,
  // from the block
  input wire stack_push_r,
  input wire [12:0] stack_push_data_r,
  input wire stack_pop_r,
  // to the block
  output reg insn_boundary,
  output wire [12:0] next_pc,
  output wire stack_full,
  output reg return_from_interrupt,
  output wire [12:0] stack_top
);
  reg [12:0] mem [0:3];
  reg [1:0] sp;
  assign next_pc = pc_in;
  assign stack_full = (sp == DEPTH);
  // top shown only in the pop cycle, garbage otherwise
  assign stack_top = stack_pop_r ? mem[sp - 2'd1] : ~mem[sp - 2'd1];
  // boundary every other cycle, slower than a real core at best
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sp <= 2'd0;
      insn_boundary <= 1'b0;
      return_from_interrupt <= 1'b0;
    end else begin
      insn_boundary <= ~insn_boundary;
      return_from_interrupt <= ret_req & ~return_from_interrupt;
      if (stack_push_r) begin
        mem[sp] <= stack_push_data_r;
        sp <= sp + 2'd1;
      end else if (stack_pop_r) begin
        sp <= sp - 2'd1;
      end
    end
  end
endmodule // core_model

// file: tb/irq_props.sv
// assertions on the vectoring block ports
`timescale 1ns/1ps
`include "irq_defines.vh"

module irq_props (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // register bus
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire [4:0] avs_address,
  input wire [31:0] avs_writedata,
  // core side
  input wire [`PC_W-1:0] next_pc,
  input wire stack_full,
  input wire return_from_interrupt,
  input wire [`PC_W-1:0] stack_top,
  input wire stack_push_r,
  input wire [`PC_W-1:0] stack_push_data_r,
  input wire stack_pop_r,
  input wire pc_load_r,
  input wire [`PC_W-1:0] pc_load_value_r,
  // pin control
  input wire ext_pull_up_en,
  input wire noise_filtered_input_pin_pull_up_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // bus answers after at most one wait cycle
  a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus wait longer than one cycle");
  a_push_with_load: assert property (stack_push_r |-> pc_load_r)
    else $error("push without vector load");
  a_push_saves_pc: assert property (stack_push_r |-> stack_push_data_r == $past(next_pc))
    else $error("pushed pc differs from next pc");
  a_vector_legal: assert property (stack_push_r |-> pc_load_value_r inside
    {`VEC_EXT, `VEC_C0, `VEC_NF, `VEC_MF0}) else $error("vector address not legal");
  a_no_nesting: assert property (stack_push_r |=> !stack_push_r [*2])
    else $error("second entry right after a take");
  a_full_holds: assert property (stack_full |=> !stack_push_r)
    else $error("push while stack full");
  a_pop_on_ret: assert property (return_from_interrupt |=> stack_pop_r)
    else $error("no pop after return");
  a_restore_pc: assert property (stack_pop_r |=> pc_load_r &&
    pc_load_value_r == $past(stack_top)) else $error("pc not restored from stack");
  a_load_cause: assert property (pc_load_r |-> stack_push_r || $past(stack_pop_r))
    else $error("pc load without cause");
  a_pull_follows: assert property (avs_write && !avs_waitrequest && avs_address == `REG_EDGE
    |=> ext_pull_up_en == $past(avs_writedata[8]) && noise_filtered_input_pin_pull_up_en == $past(avs_writedata[9]))
    else $error("pull-up enable not as written");
  c_take: cover property (stack_push_r);
  c_pop: cover property (stack_pop_r);
  c_full: cover property (stack_full ##1 stack_pop_r);
endmodule // irq_props

// file: tb/testbench.sv
// self-checking bench for the interrupt vectoring block
`timescale 1ns/1ps
`include "irq_defines.vh"

module testbench;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [4:0] avs_address = 5'h00;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h0;
  reg [5:0] src = 6'h00;
  reg ret_req = 1'b0;
  reg [12:0] pc_in = 13'h0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, ib, full, rfi, push, pop, load;
  wire [12:0] npc, top, pdata, lval;
  integer fail_count = 0;
  integer checks = 0;
  integer cyc = 0;
  reg [31:0] rq [$];
  reg [12:0] pq [$];

  always #12.5 clk = ~clk;

  irq_vectoring irq_vectoring_inst (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .filtered_hall_a(src[0]), .filtered_hall_b(src[1]), .filtered_hall_c(src[2]),
    .ext_irq_pin(src[3]), .comparator_zero_out(src[4]), .noise_filtered_input_pin(src[5]),
    .insn_boundary(ib), .next_pc(npc), .stack_full(full), .return_from_interrupt(rfi),
    .stack_top(top), .stack_push_r(push), .stack_push_data_r(pdata), .stack_pop_r(pop),
    .pc_load_r(load), .pc_load_value_r(lval), .low_power_sleep(), .low_power_idle(),
    .ext_pull_up_en(), .noise_filtered_input_pin_pull_up_en());
  core_model core_model_inst (.clk(clk), .rst_n(rst_n), .ret_req(ret_req), .pc_in(pc_in),
    .stack_push_r(push), .stack_push_data_r(pdata), .stack_pop_r(pop), .insn_boundary(ib),
    .next_pc(npc), .stack_full(full), .return_from_interrupt(rfi), .stack_top(top));

  task end_of_test;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task cmp_rd(input [31:0] e);
    checks = checks + 1;
    if (avs_readdata !== e) begin
      fail_count = fail_count + 1;
      $display("wrong value at %0t: got %h expected %h", $time, avs_readdata, e);
    end
  endtask
  task cmp_pc(input [12:0] e);
    checks = checks + 1;
    if (lval !== e) begin
      fail_count = fail_count + 1;
      $display("wrong value at %0t: got %h expected %h", $time, lval, e);
    end
  endtask
  // one avalon access, held until waitrequest is seen low
  task bus(input rd, input [4:0] a, input [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task wr(input [4:0] a, input [31:0] d);
    bus(1'b0, a, d);
  endtask
  task rd(input [4:0] a, input [31:0] e);
    rq.push_back(e);
    bus(1'b1, a, 32'h0);
  endtask
  // pin change, then enough edges for sync and flag
  task tog(input integer i);
    @(posedge clk);
    src[i] <= ~src[i];
    repeat (6) @(posedge clk);
  endtask
  task ret;
    @(posedge clk);
    ret_req <= 1'b1;
    @(posedge clk);
    ret_req <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task done(input [63:0] s);
    $display("test %0s done", s);
  endtask

  // results are matched in order against the notes of the driver
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (avs_read && avs_waitrequest === 1'b0) cmp_rd(rq.size() ? rq.pop_front() : 32'hx);
    if (load === 1'b1) cmp_pc(pq.size() ? pq.pop_front() : 13'hx);
    if (cyc == 5000) begin
      fail_count = fail_count + 1;
      end_of_test;
    end
  end

  initial begin
    pc_in = 13'($urandom(87));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(`REG_CTRL, 32'h0);
    rd(`REG_FLAGS, 32'h0);
    rd(`REG_EDGE, 32'h0);
    rd(5'h14, 32'h0);
    tog(2);
    rd(`REG_FLAGS, 32'h0);
    done("reset");
    wr(`REG_EDGE, 32'h4);
    tog(3);
    rd(`REG_FLAGS, 32'h2);
    pq.push_back(`VEC_EXT);
    wr(`REG_CTRL, 32'h5);
    rd(`REG_FLAGS, 32'h0);
    rd(`REG_CTRL, 32'h4);
    pq.push_back(pc_in);
    ret;
    done("external");
    pc_in <= 13'($urandom);
    wr(`REG_FLAGS, 32'he);
    pq.push_back(`VEC_EXT);
    wr(`REG_CTRL, 32'h1f);
    pq.push_back(`VEC_C0);
    wr(`REG_CTRL, 32'h1f);
    wr(`REG_CTRL, 32'h1f);
    rd(`REG_FLAGS, 32'h8);
    rd(`REG_CTRL, 32'h1f);
    pq.push_back(pc_in);
    pq.push_back(`VEC_NF);
    ret;
    repeat (2) pq.push_back(pc_in);
    ret;
    ret;
    done("priority");
    wr(`REG_EDGE, 32'h3);
    tog(1);
    rd(`REG_FLAGS, 32'h21);
    pq.push_back(`VEC_MF0);
    wr(`REG_CTRL, 32'h43);
    rd(`REG_FLAGS, 32'h20);
    rd(`REG_STATUS, 32'h2010);
    pq.push_back(pc_in);
    ret;
    done("hall");
    wr(`REG_EDGE, 32'h3d8);
    wr(`REG_POWER, 32'h1);
    rd(`REG_POWER, 32'h1);
    tog(4);
    rd(`REG_POWER, 32'h0);
    tog(3);
    tog(5);
    rd(`REG_FLAGS, 32'h2e);
    wr(`REG_CTRL, 32'h1);
    rd(`REG_CTRL, 32'h1);
    done("wake");
    repeat (10) @(posedge clk);
    end_of_test;
  end
endmodule // testbench

bind irq_vectoring irq_props irq_props_inst (.clk(clk), .rst_n(rst_n), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .avs_address(avs_address),
  .avs_writedata(avs_writedata), .next_pc(next_pc), .stack_full(stack_full),
  .return_from_interrupt(return_from_interrupt), .stack_top(stack_top),
  .stack_push_r(stack_push_r), .stack_push_data_r(stack_push_data_r),
  .stack_pop_r(stack_pop_r), .pc_load_r(pc_load_r), .pc_load_value_r(pc_load_value_r),
  .ext_pull_up_en(ext_pull_up_en), .noise_filtered_input_pin_pull_up_en(noise_filtered_input_pin_pull_up_en));
